// ===== rtl/hro_pkg.sv
// shared types and constants for the handler result output block
package hro_pkg;
	localparam int NUM_BINS = 8;
	localparam int NUM_UDEF = 2;
	localparam int HOLD_CYC = 2;
	localparam int BEEP_NS = 1000;
	localparam int CLK_NS = 20;
	localparam int BEEP_CYC = (BEEP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic BIN_FUNC_DEFAULT = 1'b1;

	typedef enum logic [3:0] {
		HRO_OPND_FAIL = 4'h0,
		HRO_OPND_PASS = 4'h1,
		HRO_OPND_LOW  = 4'h2,
		HRO_OPND_HIGH = 4'h3,
		HRO_OPND_BIN0 = 4'h4,
		HRO_OPND_BIN1 = 4'h5,
		HRO_OPND_BIN2 = 4'h6,
		HRO_OPND_BIN3 = 4'h7,
		HRO_OPND_BIN4 = 4'h8,
		HRO_OPND_BIN5 = 4'h9,
		HRO_OPND_BIN6 = 4'hA,
		HRO_OPND_BIN7 = 4'hB,
		HRO_OPND_BIN8 = 4'hC
	} hro_opnd_t;

	typedef enum logic [1:0] {
		HRO_OP_OR  = 2'h0,
		HRO_OP_AND = 2'h1,
		HRO_OP_OFF = 2'h2
	} hro_op_t;

	typedef enum logic [1:0] {
		HRO_BEEP_OFF  = 2'h0,
		HRO_BEEP_PASS = 2'h1,
		HRO_BEEP_FAIL = 2'h2
	} hro_beep_t;

	typedef struct packed {
		logic      active_high;
		hro_opnd_t opnd1;
		hro_op_t   op;
		hro_opnd_t opnd2;
	} hro_udef_t;

	typedef struct packed {
		logic       pass;
		logic       fail;
		logic       high;
		logic       low;
		logic [8:0] bin;
	} hro_result_t;

	typedef struct packed {
		logic      key_click_on;
		hro_beep_t compare;
		hro_beep_t binning;
	} hro_beep_cfg_t;
endpackage : hro_pkg

// ===== rtl/hro_udef_logic.sv
// one user-defined output: operand select, operator, active level
`timescale 1ns/1ns
module hro_udef_logic (
	input  wire logic             clk_sys_in,
	input  wire logic             rst_n_in,
	input  wire hro_pkg::hro_udef_t   cfg_in,
	input  wire hro_pkg::hro_result_t res_in,
	input  wire logic             bin_func_in,
	output logic                  pin_out
);
	import hro_pkg::*;

	function automatic logic opnd_val(input hro_opnd_t o, input hro_result_t r,
		input logic bins_ok);
		logic v;
		v = 1'b0;
		case (o)
			HRO_OPND_FAIL: v = r.fail;
			HRO_OPND_PASS: v = r.pass;
			HRO_OPND_LOW:  v = r.low;
			HRO_OPND_HIGH: v = r.high;
			default: v = bins_ok & r.bin[o - HRO_OPND_BIN0]; // see RQ6
		endcase
		return v;
	endfunction : opnd_val

	logic a;
	logic b;
	logic cond;

	always_comb begin
		a = opnd_val(cfg_in.opnd1, res_in, bin_func_in);
		b = opnd_val(cfg_in.opnd2, res_in, bin_func_in);
		case (cfg_in.op)
			HRO_OP_OR:  cond = a | b;
			HRO_OP_AND: cond = a & b;
			default:    cond = a; // see RQ4
		endcase
	end

	// idle level is the inactive one
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pin_out <= 1'b0;
		end else begin
			pin_out <= cond ? cfg_in.active_high : ~cfg_in.active_high; // see RQ11 see RQ9
		end
	end
endmodule : hro_udef_logic

// ===== rtl/hro_handler_out.sv
// handler port result outputs, user-defined outputs and beeper gating
//
// How it works
// RQ1: result mode is clear or hold
// RQ2: clear drops results on strobe fall
// RQ3: hold keeps old results until test done
// RQ4: off operator follows first operand only
// RQ5: bin zero means outside bins one-eight
// RQ6: no bin operands without binning function
// RQ7: beeper gated by click, compare, binning settings
// RQ8: escape discards pending user-define edit
// RQ9: per-output active level and two-operand logic
// RQ10: port active only in compare or binning
// RQ11: pin at active level while condition true
`timescale 1ns/1ns
module hro_handler_out #(
	parameter logic BIN_FUNC = hro_pkg::BIN_FUNC_DEFAULT
) (
	input  wire logic                   clk_sys_in,
	input  wire logic                   rst_n_in,
	input  wire logic                   hold_mode_in,
	input  wire logic                   compare_func_in,
	input  wire logic                   binning_func_in,
	input  wire logic                   meas_done_in,
	input  wire logic                   meas_pass_in,
	input  wire logic                   meas_fail_in,
	input  wire logic                   meas_high_in,
	input  wire logic                   meas_low_in,
	input  wire logic [7:0]             meas_bin_in,
	input  wire logic                   test_complete_strobe_in,
	input  wire logic                   edit_sel_in,
	input  wire hro_pkg::hro_udef_t     edit_cfg_in,
	input  wire logic                   edit_enter_in,
	input  wire logic                   edit_esc_in,
	input  wire hro_pkg::hro_beep_cfg_t beep_cfg_in,
	input  wire logic                   key_press_in,
	output logic                        pass_out,
	output logic                        fail_out,
	output logic                        high_out,
	output logic                        low_out,
	output logic [7:0]                  bin_out,
	output logic                        udef1_out,
	output logic                        udef2_out,
	output logic                        port_active_out,
	output logic                        beep_out
);
	import hro_pkg::*;

	logic [2:0]  eot_sync;
	logic        eot_q;
	logic        eot_fall;
	logic        eot_rise;
	hro_result_t pend;
	hro_result_t shown;
	hro_result_t gated;
	hro_udef_t   udef_cfg [NUM_UDEF];
	logic        edit_open;
	logic [$clog2(BEEP_CYC+1)-1:0] beep_cnt;
	logic        beep_req;
	logic        bin_allowed;
	logic        udef_pin [NUM_UDEF];
	logic        click_req;
	logic        cmp_req;
	logic        bin_req;
	logic        grading_on;
	logic        edit_has_bin;

	assign bin_allowed = BIN_FUNC;

	// binning only counts on the variant that has it
	assign grading_on = compare_func_in | (binning_func_in & bin_allowed); // see RQ10

	// any bin operand in the pending edit
	assign edit_has_bin = (edit_cfg_in.opnd1 >= HRO_OPND_BIN0) | (edit_cfg_in.opnd2 >= HRO_OPND_BIN0);

	// strobe from the handler cable: three stages, change once stages two and three agree
	// reset to the idle high level so no false edge follows reset
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			eot_sync <= 3'h7;
			eot_q    <= 1'b1;
		end else begin
			eot_sync <= {eot_sync[1:0], test_complete_strobe_in};
			if (eot_sync[2] == eot_sync[1]) begin
				eot_q <= eot_sync[2];
			end
		end
	end
	assign eot_fall = eot_q & (eot_sync[2] == eot_sync[1]) & ~eot_sync[2];
	assign eot_rise = ~eot_q & (eot_sync[2] == eot_sync[1]) & eot_sync[2];

	// latch newest measurement; bin zero derived here
	// a measurement after the strobe rise waits for the next test
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pend <= '0;
		end else if (meas_done_in) begin
			pend.pass <= meas_pass_in;
			pend.fail <= meas_fail_in;
			pend.high <= meas_high_in;
			pend.low  <= meas_low_in;
			pend.bin  <= {meas_bin_in, ~|meas_bin_in}; // see RQ5
		end
	end

	// clear mode blanks on strobe fall; both modes publish on strobe rise
	// one detected edge per sample, so rise and fall never meet
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			shown <= '0;
		end else if (eot_rise) begin
			shown <= pend; // see RQ2 see RQ3
		end else if (eot_fall && !hold_mode_in) begin
			shown <= '0; // see RQ1 see RQ2
		end
	end

	// port lines idle unless a grading function is running
	always_comb begin
		gated = shown;
		if (!grading_on) begin
			gated = '0; // see RQ10
		end
	end

	// registered so the cable never sees decode glitches
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pass_out        <= 1'b0;
			fail_out        <= 1'b0;
			high_out        <= 1'b0;
			low_out         <= 1'b0;
			bin_out         <= 8'h00;
			port_active_out <= 1'b0;
		end else begin
			pass_out        <= gated.pass;
			fail_out        <= gated.fail;
			high_out        <= gated.high;
			low_out         <= gated.low;
			bin_out         <= gated.bin[8:1];
			port_active_out <= grading_on; // see RQ10
		end
	end

	// edits commit on enter only; escape drops them
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			edit_open <= 1'b0;
			for (int i = 0; i < NUM_UDEF; i++) begin
				udef_cfg[i] <= '{active_high: 1'b1, opnd1: HRO_OPND_PASS,
					op: HRO_OP_OFF, opnd2: HRO_OPND_PASS};
			end
		end else if (edit_esc_in) begin
			edit_open <= 1'b0; // see RQ8
		end else if (edit_enter_in) begin
			edit_open <= 1'b0;
			// a variant without binning refuses bin operands outright
			if (!bin_allowed && edit_has_bin) begin
				udef_cfg[edit_sel_in] <= udef_cfg[edit_sel_in]; // see RQ6
			end else begin
				udef_cfg[edit_sel_in] <= edit_cfg_in;
			end
		end else begin
			edit_open <= 1'b1;
		end
	end

	for (genvar g = 0; g < NUM_UDEF; g++) begin : g_udef
		hro_udef_logic u_logic (
			.clk_sys_in  (clk_sys_in),
			.rst_n_in    (rst_n_in),
			.cfg_in      (udef_cfg[g]),
			.res_in      (gated),
			.bin_func_in (bin_allowed),
			.pin_out     (udef_pin[g])
		);
	end

	// first menu entry drives the first user pin
	assign udef1_out = udef_pin[0];
	assign udef2_out = udef_pin[1];

	// beep requests: key click, compare and binning outcomes
	assign click_req = key_press_in & beep_cfg_in.key_click_on; // see RQ7

	// compare outcome beeps once per published result
	always_comb begin
		cmp_req = 1'b0;
		if (eot_rise && compare_func_in) begin
			case (beep_cfg_in.compare)
				HRO_BEEP_PASS: cmp_req = pend.pass; // see RQ7
				HRO_BEEP_FAIL: cmp_req = pend.fail; // see RQ7
				default:       cmp_req = 1'b0;
			endcase
		end
	end

	// binning pass means inside bins one-eight
	always_comb begin
		bin_req = 1'b0;
		if (eot_rise && binning_func_in && bin_allowed) begin
			case (beep_cfg_in.binning)
				HRO_BEEP_PASS: bin_req = ~pend.bin[0]; // see RQ7
				HRO_BEEP_FAIL: bin_req = pend.bin[0]; // see RQ7
				default:       bin_req = 1'b0;
			endcase
		end
	end

	// all sources share one tone; simultaneous requests merge
	assign beep_req = click_req | cmp_req | bin_req;

	// fixed-length tone; a new request restarts it rather than queueing
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			beep_cnt <= '0;
			beep_out <= 1'b0;
		end else if (beep_req) begin
			beep_cnt <= ($clog2(BEEP_CYC+1))'(BEEP_CYC - 1);
			beep_out <= 1'b1;
		end else if (beep_cnt != '0) begin
			beep_cnt <= beep_cnt - 1'b1;
			beep_out <= 1'b1;
		end else begin
			beep_out <= 1'b0;
		end
	end
endmodule : hro_handler_out

// ===== test/hro_handler_model.sv
// handler-side model: end-of-test strobe and result sampling
`timescale 1ns/1ns
module hro_handler_model (
	input  wire logic        clk_sys_in,
	input  wire logic [11:0] res_in,
	output logic             strobe_out,
	output logic [11:0]      seen_out
);
	initial strobe_out = 1'b1;
	task automatic fall();
		@(negedge clk_sys_in);
		strobe_out = 1'b0;
		repeat (8) @(negedge clk_sys_in);
	endtask : fall
	// sample only once the synchroniser delay has surely passed
	task automatic rise();
		strobe_out = 1'b1;
		repeat (8) @(negedge clk_sys_in);
		seen_out = res_in;
	endtask : rise
endmodule : hro_handler_model

// ===== test/hro_handler_out_sva.sv
// port assertions for the handler result output block
`timescale 1ns/1ns
module hro_handler_out_sva (
	input wire logic                   clk_sys_in,
	input wire logic                   rst_n_in,
	input wire logic                   hold_mode_in,
	input wire logic                   compare_func_in,
	input wire logic                   binning_func_in,
	input wire logic                   test_complete_strobe_in,
	input wire logic                   key_press_in,
	input wire hro_pkg::hro_beep_cfg_t beep_cfg_in,
	input wire logic                   pass_out,
	input wire logic                   fail_out,
	input wire logic                   high_out,
	input wire logic                   low_out,
	input wire logic [7:0]             bin_out,
	input wire logic                   udef1_out,
	input wire logic                   port_active_out,
	input wire logic                   beep_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_port_idle: assert property ((!compare_func_in && !binning_func_in) [*3] |->
		!port_active_out && !pass_out && !fail_out && !high_out && !low_out)
		else $error("results not idle with port inactive");
	a_port_on: assert property (compare_func_in [*2] |-> port_active_out)
		else $error("port not active in compare");
	a_clear_drop: assert property ((!hold_mode_in && !test_complete_strobe_in) [*7] |->
		!pass_out && !fail_out && !high_out && !low_out)
		else $error("results not cleared after strobe fall");
	a_hold_keep: assert property ((hold_mode_in && !test_complete_strobe_in) [*7] |->
		$stable({pass_out, fail_out, high_out, low_out, bin_out}))
		else $error("results moved before test done");
	a_load_rise: assert property ($rose(pass_out) && $past(port_active_out) |->
		$past(test_complete_strobe_in, 3))
		else $error("pass rose without strobe rise");
	a_click_beep: assert property (key_press_in && beep_cfg_in.key_click_on |->
		##[1:3] beep_out)
		else $error("no key click beep");
	a_beep_len: assert property ($rose(beep_out) |-> beep_out [*8])
		else $error("beep too short");
	a_reset_zero: assert property (disable iff (1'b0) !rst_n_in |=>
		!pass_out && !fail_out && !udef1_out && !beep_out && !port_active_out)
		else $error("outputs not zero after reset");
endmodule : hro_handler_out_sva

bind hro_handler_out hro_handler_out_sva hro_handler_out_sva_inst (
	.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hold_mode_in(hold_mode_in),
	.compare_func_in(compare_func_in), .binning_func_in(binning_func_in),
	.test_complete_strobe_in(test_complete_strobe_in), .key_press_in(key_press_in),
	.beep_cfg_in(beep_cfg_in), .pass_out(pass_out), .fail_out(fail_out), .high_out(high_out),
	.low_out(low_out), .bin_out(bin_out), .udef1_out(udef1_out),
	.port_active_out(port_active_out), .beep_out(beep_out));

// ===== test/tb_top.sv
// self-checking bench for the handler result outputs
`timescale 1ns/1ns
module tb_top;
	import hro_pkg::*;
	typedef struct packed {
		logic [3:0] res;
		logic [7:0] bin;
		hro_udef_t  cfg;
		logic       exp;
	} hro_row_t;
	logic          clk_sys_in = 1'b0;
	logic          rst_n_in = 1'b0;
	logic          hold_mode_in = 1'b0;
	logic          compare_func_in = 1'b1;
	logic          binning_func_in = 1'b0;
	logic          meas_done_in = 1'b0;
	logic [3:0]    res = 4'h0;
	logic [7:0]    meas_bin_in = 8'h00;
	logic          edit_enter_in = 1'b0;
	logic          edit_esc_in = 1'b0;
	logic          key_press_in = 1'b0;
	hro_udef_t     edit_cfg_in = '0;
	hro_beep_cfg_t beep_cfg_in = {1'b1, HRO_BEEP_PASS, HRO_BEEP_FAIL};
	logic          pass_out, fail_out, high_out, low_out, udef1_out, port_active_out, beep_out;
	logic [7:0]    bin_out;
	logic          strobe;
	logic [11:0]   seen;
	int            n_errors = 0;
	int            n_compared = 0;
	int            cyc = 0;
	hro_row_t      rows[6] = '{
		'{4'h8, 8'h01, '{1'b1, HRO_OPND_PASS, HRO_OP_OFF, HRO_OPND_FAIL}, 1'b1},
		'{4'h6, 8'h00, '{1'b1, HRO_OPND_HIGH, HRO_OP_AND, HRO_OPND_FAIL}, 1'b1},
		'{4'h1, 8'h00, '{1'b0, HRO_OPND_PASS, HRO_OP_OR, HRO_OPND_BIN0}, 1'b0},
		'{4'h8, 8'h80, '{1'b1, HRO_OPND_BIN8, HRO_OP_AND, HRO_OPND_FAIL}, 1'b0},
		'{4'h8, 8'h04, '{1'b1, HRO_OPND_FAIL, HRO_OP_OFF, HRO_OPND_BIN3}, 1'b0},
		'{4'h4, 8'h00, '{1'b1, HRO_OPND_LOW, HRO_OP_OR, HRO_OPND_BIN0}, 1'b1}};

	hro_handler_out hro_handler_out_inst (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .hold_mode_in(hold_mode_in),
		.compare_func_in(compare_func_in), .binning_func_in(binning_func_in),
		.meas_done_in(meas_done_in),
		.meas_pass_in(res[3]), .meas_fail_in(res[2]), .meas_high_in(res[1]),
		.meas_low_in(res[0]), .meas_bin_in(meas_bin_in), .test_complete_strobe_in(strobe),
		.edit_sel_in(1'b0), .edit_cfg_in(edit_cfg_in), .edit_enter_in(edit_enter_in),
		.edit_esc_in(edit_esc_in), .beep_cfg_in(beep_cfg_in), .key_press_in(key_press_in),
		.pass_out(pass_out), .fail_out(fail_out), .high_out(high_out), .low_out(low_out),
		.bin_out(bin_out), .udef1_out(udef1_out), .udef2_out(),
		.port_active_out(port_active_out), .beep_out(beep_out));
	hro_handler_model hro_handler_model_inst (.clk_sys_in(clk_sys_in),
		.res_in({pass_out, fail_out, high_out, low_out, bin_out}), .strobe_out(strobe),
		.seen_out(seen));

	initial forever #10 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic pulse_in(logic [3:0] r, logic [7:0] b, hro_udef_t c, logic esc);
		@(negedge clk_sys_in);
		res = r;
		meas_bin_in = b;
		edit_cfg_in = c;
		meas_done_in = 1'b1;
		edit_enter_in = 1'b1;
		edit_esc_in = esc;
		@(negedge clk_sys_in);
		meas_done_in = 1'b0;
		edit_enter_in = 1'b0;
		edit_esc_in = 1'b0;
	endtask : pulse_in
	task automatic wrap_up();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (8) @(negedge clk_sys_in);
		rst_n_in = 1'b1;
		chk("reset", 12'h000, {pass_out, fail_out, high_out, low_out, bin_out});
		foreach (rows[i]) begin
			pulse_in(rows[i].res, rows[i].bin, rows[i].cfg, 1'b0);
			hro_handler_model_inst.fall();
			chk("cleared", 12'h000, {pass_out, fail_out, high_out, low_out, bin_out});
			hro_handler_model_inst.rise();
			chk("results", {rows[i].res, rows[i].bin}, seen);
			chk("user pin", {11'h000, rows[i].exp}, {11'h000, udef1_out});
		end
		// hold mode: old results must survive the strobe low phase
		hold_mode_in = 1'b1;
		pulse_in(4'h2, 8'h02, rows[0].cfg, 1'b0);
		hro_handler_model_inst.fall();
		chk("held", 12'h400, {pass_out, fail_out, high_out, low_out, bin_out});
		hro_handler_model_inst.rise();
		chk("updated", 12'h202, seen);
		pulse_in(4'h2, 8'h02, '{1'b0, HRO_OPND_PASS, HRO_OP_OFF, HRO_OPND_FAIL}, 1'b1);
		repeat (4) @(negedge clk_sys_in);
		chk("escaped edit", 12'h000, {11'h000, udef1_out});
		key_press_in = 1'b1;
		@(negedge clk_sys_in);
		key_press_in = 1'b0;
		repeat (3) @(negedge clk_sys_in);
		chk("key click", 12'h001, {11'h000, beep_out});
		compare_func_in = 1'b0;
		repeat (4) @(negedge clk_sys_in);
		chk("port off", 12'h000, {7'h00, port_active_out, pass_out, fail_out, high_out, low_out});
		binning_func_in = 1'b1;
		repeat (4) @(negedge clk_sys_in);
		chk("port binning", 12'h001, {11'h000, port_active_out});
		wrap_up();
	end
endmodule : tb_top
